// file: core/cpd_device.sv
/*
  Device end of the link: serial slave of one chained potentiometer,
  holding the wiper, the power-up value, fourteen user words and the
  access control bits. Assumes the link pins are asynchronous to
  i_clock and toggle no faster than about eight system clocks.
*/
// Chosen here: the strobed register port.
`timescale 1ns/1ps
module cpd_device
  import cpd_pkg::*;
#(
  parameter int unsigned NV_WRITE_COUNT = CPD_NV_WRITE_CYCLES
)
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Link
  cpd_if.device link,
  // User side status
  output logic [7:0] o_wiper,
  output logic o_shutdown,
  output logic o_write_in_progress
);

  // Pin sampling, bit order {serial_in, sclk, cs_b}
  logic [2:0] pin_s1_reg; // First stage, read by stage two only
  logic [2:0] pin_s2_reg; // Second stage
  logic [2:0] pin_s3_reg; // Third stage
  logic [2:0] pin_reg; // Accepted levels
  logic [2:0] pin_next; // Accepted levels, next

  // Link datapath
  logic [15:0] shift_reg; // Last sixteen bits taken in
  logic out_bit_reg; // Bit being driven out
  logic pend_reg; // A read waits for the next frame
  logic [7:0] pend_cmd_reg; // Its command byte, echoed back

  // Register state
  logic [7:0] wiper_reg; // Wiper position, volatile
  logic [7:0] nv_reg [0:CPD_NV_WORDS-1]; // 0 is power-up, rest user
  logic volatile_reg; // Address zero goes to wiper only
  logic run_reg; // Low means shutdown
  logic open_drain_reg; // Output drives low only
  logic recall_reg; // Power-up copy still owed
  logic [31:0] nv_cnt_reg; // Non-volatile write timer

  // Accept a level only when the last two stages agree
  assign pin_next = (pin_s2_reg & ~(pin_s2_reg ^ pin_s3_reg))
    | (pin_reg & (pin_s2_reg ^ pin_s3_reg));

  // Edges of the accepted levels
  wire cs_low = ~pin_reg[0];
  wire cs_fall = pin_reg[0] & ~pin_next[0];
  wire cs_rise = ~pin_reg[0] & pin_next[0];
  wire clk_rise = cs_low & ~pin_reg[1] & pin_next[1];
  wire clk_fall = cs_low & pin_reg[1] & ~pin_next[1];
  wire data_in = pin_reg[2];

  // Command fields of the final two bytes held
  wire [7:0] cmd = shift_reg[15:8];
  wire [2:0] op = cmd[CPD_OP_MSB:CPD_OP_LSB];
  wire [4:0] addr = cmd[CPD_ADDR_MSB:0];
  wire [7:0] wdata = shift_reg[7:0];

  // Address decode
  wire busy = (nv_cnt_reg != 32'h0);
  wire hit_zero = (addr == CPD_ADDR_WIPER);
  wire hit_acc = (addr == CPD_ADDR_ACCESS);
  wire hit_user = (addr >= CPD_ADDR_USER_FIRST)
    & (addr <= CPD_ADDR_USER_LAST);
  wire is_read = (op == CPD_OP_ACC_RD) | (op == CPD_OP_REG_RD);
  // Writes are refused while a non-volatile write runs
  wire wr_ok = cs_rise & ~busy;
  wire wr_acc = wr_ok & ((op == CPD_OP_ACC_WR)
    | ((op == CPD_OP_REG_WR) & hit_acc));
  wire wr_zero = wr_ok & (op == CPD_OP_REG_WR) & hit_zero;
  wire wr_user = wr_ok & (op == CPD_OP_REG_WR) & hit_user;
  wire wr_wiper_only = wr_zero & volatile_reg;
  wire wr_power_up = wr_zero & ~volatile_reg;
  wire wr_nv = wr_power_up | wr_user;
  wire [3:0] user_idx = addr[3:0];

  // Read source, taken when the answering frame opens
  wire [4:0] pend_addr = (pend_cmd_reg[CPD_OP_MSB:CPD_OP_LSB]
    == CPD_OP_ACC_RD) ? CPD_ADDR_ACCESS : pend_cmd_reg[CPD_ADDR_MSB:0];
  wire pend_user = (pend_addr >= CPD_ADDR_USER_FIRST)
    & (pend_addr <= CPD_ADDR_USER_LAST);
  wire [7:0] acc_view = {volatile_reg, run_reg, busy, 3'h0,
    open_drain_reg, 1'b0};
  // Address zero reads the wiper only in volatile mode
  wire [7:0] zero_view = volatile_reg ? wiper_reg : nv_reg[0];
  // Reserved and unmapped addresses answer zero
  wire [7:0] read_value = (pend_addr == CPD_ADDR_ACCESS) ? acc_view
    : (pend_addr == CPD_ADDR_WIPER) ? zero_view
    : pend_user ? nv_reg[pend_addr[3:0]] : 8'h00;
  // Answer frame: command echo, then data
  wire [15:0] frame_load = pend_reg ? {pend_cmd_reg, read_value} : 16'h0;

  // Output pin: released while deselected, and in open drain for ones
  assign link.serial_out_data = open_drain_reg ? 1'b0 : out_bit_reg;
  assign link.serial_out_oe_b = pin_reg[0]
    | (open_drain_reg & out_bit_reg);
  assign o_wiper = wiper_reg;
  assign o_shutdown = ~run_reg;
  assign o_write_in_progress = busy;

  // Three stage pin sampler
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      pin_s1_reg <= CPD_RST_PINS;
      pin_s2_reg <= CPD_RST_PINS;
      pin_s3_reg <= CPD_RST_PINS;
      pin_reg <= CPD_RST_PINS;
    end
    else
    begin
      pin_s1_reg <= {link.serial_in, link.sclk, link.cs_b};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      pin_reg <= pin_next;
    end
  end

  // Shift register: in on rising, out on falling
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      shift_reg <= 16'h0;
      out_bit_reg <= 1'b0;
    end
    else if (cs_fall)
    begin
      // A held read answer replaces the stale frame contents
      shift_reg <= frame_load;
      out_bit_reg <= frame_load[15];
    end
    else if (clk_rise)
      shift_reg <= {shift_reg[14:0], data_in};
    else if (clk_fall)
      // Bit taken sixteen rising edges ago goes downstream
      out_bit_reg <= shift_reg[15];
  end

  // Held read: stored at one release, used at the next select
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      pend_reg <= 1'b0;
      pend_cmd_reg <= 8'h00;
    end
    else if (cs_rise)
    begin
      // Executed with the whole chain at release
      pend_reg <= is_read;
      pend_cmd_reg <= cmd;
    end
    else if (cs_fall)
      pend_reg <= 1'b0;
  end

  // Access control bits; the busy bit is not writable
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      volatile_reg <= CPD_RST_VOLATILE;
      run_reg <= CPD_RST_RUN;
      open_drain_reg <= CPD_RST_OPEN_DRAIN;
    end
    else if (wr_acc)
    begin
      volatile_reg <= wdata[CPD_ACC_VOLATILE];
      run_reg <= wdata[CPD_ACC_RUN];
      open_drain_reg <= wdata[CPD_ACC_OPEN_DRAIN];
    end
  end

  // Wiper: factory centre in reset, then the stored start value
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      wiper_reg <= CPD_RST_WIPER;
      recall_reg <= 1'b1;
    end
    else if (recall_reg)
    begin
      wiper_reg <= nv_reg[0];
      recall_reg <= 1'b0;
    end
    else if (wr_wiper_only | wr_power_up)
      wiper_reg <= wdata;
  end

  // Non-volatile words; reset stands for the first power-up
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      nv_reg[0] <= CPD_RST_POWER_UP;
      for (int i = 1; i < CPD_NV_WORDS; i++)
        nv_reg[i] <= CPD_RST_USER;
    end
    else if (wr_power_up)
      nv_reg[0] <= wdata;
    else if (wr_user)
      nv_reg[user_idx] <= wdata;
  end

  // Busy timer from the release that commits a stored write
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      nv_cnt_reg <= 32'h0;
    else if (wr_nv)
      nv_cnt_reg <= 32'(NV_WRITE_COUNT);
    else if (busy)
      nv_cnt_reg <= nv_cnt_reg - 32'h1;
  end

endmodule : cpd_device

// file: core/cpd_host.sv
/*
  Host end of the link: shifts a frame of up to eight bytes out,
  capturing the returned bytes, under a small register port.
  Assumes software orders the bytes for the chain and issues the
  read phases as separate frames.
*/
`timescale 1ns/1ps
module cpd_host
  import cpd_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Register port
  input wire logic [3:0] i_address,
  input wire logic [7:0] i_write_data,
  input wire logic i_write,
  input wire logic i_read,
  output logic [7:0] o_read_data,
  // Link
  cpd_if.host link
);

  // Frame engine states, Gray along the path except the step from gap to idle
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_LEAD = 3'h1,
    ST_HIGH = 3'h3,
    ST_LOW = 3'h2,
    ST_TAIL = 3'h7,
    ST_GAP = 3'h5
  } cpd_state_t;

  cpd_state_t state_reg; // Engine state
  logic [4:0] cnt_reg; // Phase timer
  logic [2:0] bit_reg; // Bit within byte
  logic [2:0] byte_reg; // Byte within frame
  logic [3:0] len_reg; // Frame length in bytes
  logic last_reg; // Final bit taken
  logic [7:0] sh_reg; // Out and in shift byte
  logic sclk_reg, cs_b_reg, mosi_reg; // Pin drivers
  logic [7:0] tx_reg [0:CPD_HOST_MAX_BYTES-1]; // Bytes to send
  logic [7:0] rx_reg [0:CPD_HOST_MAX_BYTES-1]; // Bytes received
  logic [2:0] miso_sync_reg; // Three stage input sampler
  logic miso_reg; // Accepted input level
  logic [7:0] read_data_reg; // Port answer

  // Decodes of the register port
  wire busy = (state_reg != ST_IDLE);
  wire ctrl_hit = (i_address == CPD_HOST_CTRL);
  wire byte_hit = i_address[3];
  wire [2:0] byte_idx = i_address[2:0];
  wire [3:0] req_len = i_write_data[3:0];
  // Zero or oversize lengths are ignored rather than clipped
  wire start = i_write & ctrl_hit & ~busy & (req_len != 4'h0)
    & (req_len <= 4'(CPD_HOST_MAX_BYTES));
  wire tick = (cnt_reg == 5'h00);
  wire [7:0] sh_in = {sh_reg[6:0], miso_reg};
  wire byte_end = (bit_reg == 3'h7);
  wire [2:0] byte_nx = byte_reg + 3'h1;
  wire frame_end = byte_end & ({1'b0, byte_reg} == len_reg - 4'h1);
  wire [7:0] ctrl_view = {busy, 3'h0, len_reg};
  wire [7:0] read_mux = ctrl_hit ? ctrl_view
    : (byte_hit ? rx_reg[byte_idx] : 8'h00);
  wire rise_now = tick & ((state_reg == ST_LEAD) | (state_reg == ST_LOW));

  // Pins are plain flops; serial_in changes only after a fall
  assign link.sclk = sclk_reg;
  assign link.cs_b = cs_b_reg;
  assign link.serial_in = mosi_reg;
  assign o_read_data = read_data_reg;

  // Input sampler: accept a level once stages two and three agree
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      miso_sync_reg <= 3'h7;
      miso_reg <= 1'b1;
    end
    else
    begin
      miso_sync_reg <= {miso_sync_reg[1:0], link.serial_out_line};
      if (miso_sync_reg[1] == miso_sync_reg[2])
        miso_reg <= miso_sync_reg[2];
    end
  end

  // Port answer, one cycle after the read strobe
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      read_data_reg <= 8'h00;
    else if (i_read)
      read_data_reg <= read_mux;
  end

  // Transmit buffer, writable only between frames
  always_ff @(posedge i_clock)
  begin
    if (i_write & byte_hit & ~busy)
      tx_reg[byte_idx] <= i_write_data;
  end

  // Receive buffer, one byte per eight rising edges
  always_ff @(posedge i_clock)
  begin
    if (rise_now & byte_end)
      rx_reg[byte_reg] <= sh_in;
  end

  // Frame engine, mode 0, most significant bit first
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= 5'h00;
      bit_reg <= 3'h0;
      byte_reg <= 3'h0;
      len_reg <= 4'h0;
      last_reg <= 1'b0;
      sh_reg <= 8'h00;
      sclk_reg <= 1'b0;
      cs_b_reg <= 1'b1;
      mosi_reg <= 1'b0;
    end
    else
    begin
      if (!tick)
        cnt_reg <= cnt_reg - 5'h01;
      case (state_reg)
        ST_IDLE:
        begin
          // One select for the whole chain, byte 0 first
          if (start)
          begin
            cs_b_reg <= 1'b0;
            len_reg <= req_len;
            sh_reg <= tx_reg[0];
            mosi_reg <= tx_reg[0][7];
            bit_reg <= 3'h0;
            byte_reg <= 3'h0;
            last_reg <= 1'b0;
            cnt_reg <= 5'(CPD_HALF_CYCLES - 1);
            state_reg <= ST_LEAD;
          end
        end
        ST_LEAD, ST_LOW:
        begin
          // Rising edge: device and host both sample here
          if (tick)
          begin
            sclk_reg <= 1'b1;
            bit_reg <= bit_reg + 3'h1;
            last_reg <= frame_end;
            sh_reg <= sh_in;
            if (byte_end)
            begin
              byte_reg <= byte_nx;
              sh_reg <= tx_reg[byte_nx];
            end
            cnt_reg <= 5'(CPD_HALF_CYCLES - 1);
            state_reg <= ST_HIGH;
          end
        end
        ST_HIGH:
        begin
          // Falling edge: new output bit unless frame done
          if (tick)
          begin
            sclk_reg <= 1'b0;
            cnt_reg <= 5'(CPD_HALF_CYCLES - 1);
            if (last_reg)
              state_reg <= ST_TAIL;
            else
            begin
              mosi_reg <= sh_reg[7];
              state_reg <= ST_LOW;
            end
          end
        end
        ST_TAIL:
        begin
          // Raising select commits every device in the chain
          if (tick)
          begin
            cs_b_reg <= 1'b1;
            cnt_reg <= 5'(CPD_GAP_CYCLES - 1);
            state_reg <= ST_GAP;
          end
        end
        ST_GAP:
        begin
          // Hold select high long enough for the device filters
          if (tick)
            state_reg <= ST_IDLE;
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule : cpd_host

// file: core/cpd_if.sv
/*
  Serial link between one host and one potentiometer device.
  The result wire of the device output is worked out here from its
  enable; an idle line reads high, as with an external pull-up.
*/
`timescale 1ns/1ps
interface cpd_if;
  logic sclk; // Serial clock, host driven
  logic cs_b; // Chip select, active low
  logic serial_in; // Host to device data
  logic serial_out_data; // Device output level
  logic serial_out_oe_b; // Device output enable, low drives
  logic serial_out_line; // Resolved wire level

  // Pulled high whenever the device lets go of the wire
  assign serial_out_line = serial_out_oe_b ? 1'b1 : serial_out_data;

  modport device (
    input sclk,
    input cs_b,
    input serial_in,
    output serial_out_data,
    output serial_out_oe_b
  );

  modport host (
    output sclk,
    output cs_b,
    output serial_in,
    input serial_out_line
  );
endinterface : cpd_if

// file: core/cpd_pkg.sv
/*
  Shared constants for the chained potentiometer serial front end:
  command codes, register addresses, access control bit positions,
  reset values and timing counts for both link ends.
  Assumes a 200 MHz system clock on both ends.
*/
package cpd_pkg;

  // Command byte layout: operation in the top three bits
  localparam int CPD_OP_MSB = 7;
  localparam int CPD_OP_LSB = 5;
  localparam int CPD_ADDR_MSB = 4;

  // Operation codes
  localparam logic [2:0] CPD_OP_NOP = 3'h0;
  localparam logic [2:0] CPD_OP_ACC_RD = 3'h1;
  localparam logic [2:0] CPD_OP_ACC_WR = 3'h3;
  localparam logic [2:0] CPD_OP_REG_RD = 3'h4;
  localparam logic [2:0] CPD_OP_REG_WR = 3'h6;

  // Register addresses
  localparam logic [4:0] CPD_ADDR_WIPER = 5'h00;
  localparam logic [4:0] CPD_ADDR_USER_FIRST = 5'h01;
  localparam logic [4:0] CPD_ADDR_USER_LAST = 5'h0E;
  localparam logic [4:0] CPD_ADDR_ACCESS = 5'h10;
  localparam int CPD_NV_WORDS = 15;

  // Access control bit positions
  localparam int CPD_ACC_VOLATILE = 7;
  localparam int CPD_ACC_RUN = 6;
  localparam int CPD_ACC_BUSY = 5;
  localparam int CPD_ACC_OPEN_DRAIN = 1;

  // Values after reset
  localparam logic [7:0] CPD_RST_WIPER = 8'h80;
  localparam logic [7:0] CPD_RST_POWER_UP = 8'h80;
  localparam logic [7:0] CPD_RST_USER = 8'h00;
  localparam logic CPD_RST_VOLATILE = 1'b0;
  localparam logic CPD_RST_RUN = 1'b1;
  localparam logic CPD_RST_OPEN_DRAIN = 1'b0;
  localparam logic [2:0] CPD_RST_PINS = 3'h1;

  // Timing
  localparam int CPD_CLOCK_MHZ = 200;
  localparam int CPD_NV_WRITE_MS = 20;
  localparam int CPD_NV_WRITE_CYCLES = CPD_NV_WRITE_MS * 1000 * CPD_CLOCK_MHZ;
  localparam int CPD_HALF_NS = 60;
  localparam int CPD_HALF_CYCLES = CPD_HALF_NS * CPD_CLOCK_MHZ / 1000;
  localparam int CPD_GAP_CYCLES = 2 * CPD_HALF_CYCLES;

  // Host command port map
  localparam logic [3:0] CPD_HOST_CTRL = 4'h0;
  localparam int CPD_HOST_BYTE_BASE = 8;
  localparam int CPD_HOST_MAX_BYTES = 8;

endpackage : cpd_pkg

// file: tb/cpd_link_assertions.sv
/*
  Checker for the link pins of the first device in the chain.
  Assumes one system clock and reset shared by host and devices.
*/
`timescale 1ns/1ps
module cpd_link_assertions (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Link
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic serial_in,
  input wire logic serial_out_data,
  input wire logic serial_out_oe_b,
  input wire logic serial_out_line
);
  logic sclk_reg; // Previous serial clock sample
  logic [15:0] hist_reg; // Last sixteen sampled input bits
  logic [5:0] bits_reg; // Rising edges seen in this frame
  wire logic rise = sclk && !sclk_reg; // Serial clock rising edge

  default clocking dc @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_b);

  // History of input bits; the edge count is cleared between frames
  // so that the read answer in the first sixteen bits is never compared
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      sclk_reg <= 1'b0;
      hist_reg <= 16'h0000;
      bits_reg <= 6'h00;
    end
    else
    begin
      sclk_reg <= sclk;
      if (cs_b)
        bits_reg <= 6'h00;
      else if (rise)
      begin
        hist_reg <= {hist_reg[14:0], serial_in};
        bits_reg <= bits_reg + 6'h01;
      end
    end
  end

  chk_delay_sixteen: assert property (
    rise && !cs_b && bits_reg >= 6'h10 |-> serial_out_line == hist_reg[15])
    else $error("output is not input sixteen bits late");
  chk_change_low: assert property (
    !cs_b && $changed(serial_out_data) |-> !sclk)
    else $error("output changed while serial clock high");
  chk_in_stable: assert property (
    sclk |-> $stable(serial_in))
    else $error("input changed while serial clock high");
  chk_drive_frame: assert property (
    $fell(cs_b) |-> ##[1:8] !serial_out_oe_b)
    else $error("output not driven in frame");
  chk_release_fast: assert property (
    $rose(cs_b) |-> ##[1:8] serial_out_oe_b)
    else $error("output not released after frame");
  chk_sclk_idle: assert property (
    cs_b |-> !sclk)
    else $error("serial clock high while deselected");
  chk_sclk_high: assert property (
    $rose(sclk) |-> sclk [*8])
    else $error("serial clock high phase too short");
  chk_gap_high: assert property (
    $rose(cs_b) |-> cs_b [*8])
    else $error("select gap too short");

  cov_frame_end: cover property ($rose(cs_b));
  cov_long_frame: cover property (rise && bits_reg == 6'h1F);
  cov_driven: cover property ($fell(serial_out_oe_b));
endmodule : cpd_link_assertions

// file: tb/cpd_tb.sv
/*
  Bench for a chain of two devices run by the host end.
  Assumes the host register map and link timing of the core.
*/
`timescale 1ns/1ps
module cpd_tb;
  import cpd_pkg::*;
  localparam int unsigned NV_COUNT = 4000; // Outlasts three frames
  localparam int LIMIT = 40000; // Cycle ceiling of the run
  logic i_clock = 1'b0;
  logic i_rst_b = 1'b0;
  logic [3:0] address = 4'h0;
  logic [7:0] write_data = 8'h00;
  logic write = 1'b0;
  logic read = 1'b0;
  logic [7:0] read_data, wiper_a, wiper_b;
  logic shut_a, shut_b, busy_a, busy_b;
  logic [7:0] rx [4]; // Bytes returned by the last frame
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  cpd_if link_h ();
  cpd_if link_a ();
  cpd_if link_b ();

  // Shared select and clock; output of the first feeds the last
  assign link_a.sclk = link_h.sclk;
  assign link_a.cs_b = link_h.cs_b;
  assign link_a.serial_in = link_h.serial_in;
  assign link_b.sclk = link_h.sclk;
  assign link_b.cs_b = link_h.cs_b;
  assign link_b.serial_in = link_a.serial_out_line;
  assign link_h.serial_out_data = link_b.serial_out_data;
  assign link_h.serial_out_oe_b = link_b.serial_out_oe_b;

  cpd_host i_cpd_host (.i_clock(i_clock), .i_rst_b(i_rst_b),
    .i_address(address), .i_write_data(write_data), .i_write(write),
    .i_read(read), .o_read_data(read_data), .link(link_h));
  cpd_device #(.NV_WRITE_COUNT(NV_COUNT)) i_cpd_device_first (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .link(link_a),
    .o_wiper(wiper_a), .o_shutdown(shut_a),
    .o_write_in_progress(busy_a));
  cpd_device #(.NV_WRITE_COUNT(NV_COUNT)) i_cpd_device_last (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .link(link_b),
    .o_wiper(wiper_b), .o_shutdown(shut_b),
    .o_write_in_progress(busy_b));
  cpd_link_assertions i_cpd_link_assertions (.i_clock(i_clock),
    .i_rst_b(i_rst_b), .sclk(link_a.sclk), .cs_b(link_a.cs_b),
    .serial_in(link_a.serial_in),
    .serial_out_data(link_a.serial_out_data),
    .serial_out_oe_b(link_a.serial_out_oe_b),
    .serial_out_line(link_a.serial_out_line));

  // System clock, 5 ns period
  always #2.5 i_clock = ~i_clock;

  // Hang guard: a run past the ceiling counts as a mismatch
  always @(posedge i_clock)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clock);
    address <= a;
    write_data <= d;
    write <= 1'b1;
    @(posedge i_clock);
    write <= 1'b0;
  endtask : reg_write

  // Read data stands from the cycle after the strobe until the next strobe
  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clock);
    address <= a;
    read <= 1'b1;
    @(posedge i_clock);
    read <= 1'b0;
    #1 d = read_data;
  endtask : reg_read

  // Four-byte frame: last device's pair first, then poll idle
  task automatic frame(input logic [7:0] b0, b1, b2, b3);
    logic [7:0] b [4];
    logic [7:0] st;
    int n;
    b = '{b0, b1, b2, b3};
    for (int k = 0; k < 4; k++)
      reg_write(4'(CPD_HOST_BYTE_BASE + k), b[k]);
    reg_write(CPD_HOST_CTRL, 8'h04);
    n = 0;
    st = 8'h80;
    while (st[7] !== 1'b0 && n < 2000)
    begin
      reg_read(CPD_HOST_CTRL, st);
      n++;
    end
    check({7'h00, st[7]}, 8'h00);
    for (int k = 0; k < 4; k++)
      reg_read(4'(CPD_HOST_BYTE_BASE + k), rx[k]);
  endtask : frame

  // Bounded wait for both stores to finish
  task automatic wait_nv();
    int n;
    n = 0;
    while ((busy_a | busy_b) !== 1'b0 && n < 5000)
    begin
      @(posedge i_clock);
      #1;
      n++;
    end
    check({7'h00, busy_a | busy_b}, 8'h00);
  endtask : wait_nv

  task automatic test_reset();
    check(wiper_a, CPD_RST_POWER_UP);
    check(wiper_b, CPD_RST_POWER_UP);
    check({6'h00, shut_a, shut_b}, 8'h00);
    frame(8'h90, 8'h00, 8'h80, 8'h00);
    frame(8'h00, 8'h00, 8'h00, 8'h00);
    check(rx[0], 8'h90);
    check(rx[1], 8'h40);
    check(rx[2], 8'h80);
    check(rx[3], CPD_RST_POWER_UP);
  endtask : test_reset

  task automatic test_nv_write();
    frame(8'hC0, 8'h5A, 8'hC0, 8'h3C);
    check({7'h00, busy_a}, 8'h01);
    check(wiper_b, 8'h5A);
    check(wiper_a, 8'h3C);
    // A write landing while the store runs must be dropped
    frame(8'hC0, 8'h77, 8'hC0, 8'h77);
    // Status stays readable over the link while the store runs
    frame(8'h20, 8'h00, 8'h20, 8'h00);
    frame(8'h00, 8'h00, 8'h00, 8'h00);
    check(rx[0], 8'h20);
    check(rx[1], 8'h60);
    check(rx[2], 8'h20);
    check(rx[3], 8'h60);
    wait_nv();
    check(wiper_b, 8'h5A);
    check(wiper_a, 8'h3C);
  endtask : test_nv_write

  task automatic test_volatile();
    frame(8'h60, 8'h80, 8'h60, 8'hC0); // Last device shut down
    check({7'h00, shut_b}, 8'h01);
    check({7'h00, shut_a}, 8'h00);
    frame(8'hC0, 8'h11, 8'hC0, 8'h22);
    check({7'h00, busy_a | busy_b}, 8'h00);
    check(wiper_b, 8'h11);
    check(wiper_a, 8'h22);
    frame(8'h60, 8'h40, 8'h60, 8'h40);
    check({7'h00, shut_b}, 8'h00);
    frame(8'h80, 8'h00, 8'h90, 8'h00);
    frame(8'h00, 8'h00, 8'h00, 8'h00);
    check(rx[0], 8'h80);
    check(rx[1], 8'h5A);
    check(rx[2], 8'h90);
    check(rx[3], 8'h40);
    check(wiper_b, 8'h11);
    check(wiper_a, 8'h22);
  endtask : test_volatile

  task automatic test_user();
    frame(8'hC1, 8'hA5, 8'hCE, 8'h5C);
    wait_nv();
    frame(8'h81, 8'h00, 8'h8E, 8'h00);
    frame(8'h00, 8'h00, 8'h00, 8'h00);
    check(rx[0], 8'h81);
    check(rx[1], 8'hA5);
    check(rx[2], 8'h8E);
    check(rx[3], 8'h5C);
  endtask : test_user

  // Last device drives lows only; the line pull-up gives the ones
  task automatic test_open_drain();
    frame(8'h60, 8'h42, 8'h60, 8'h40);
    frame(8'h90, 8'h00, 8'h90, 8'h00);
    frame(8'h00, 8'h00, 8'h00, 8'h00);
    check(rx[0], 8'h90);
    check(rx[1], 8'h42);
    check(rx[2], 8'h90);
    check(rx[3], 8'h40);
  endtask : test_open_drain

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  // Main sequence after twenty cycles of reset
  initial
  begin
    repeat (20) @(posedge i_clock);
    i_rst_b <= 1'b1;
    repeat (8) @(posedge i_clock);
    test_reset();
    test_nv_write();
    test_volatile();
    test_user();
    test_open_drain();
    print_verdict();
  end
endmodule : cpd_tb
